// *** core/lbcc_top.sv ***
// Local bus configuration controls with a classic Wishbone register slave.
// Summary of operation
// [R1] Combining only acts in local bus mode; otherwise separate tx and rx acknowledges.
// [R2] Combining merges each channel's tx and rx acknowledge onto one pin.
// [R3] Each freed pin carries its phase-one clock only when its own direction bit (0 for channel A, 1 for channel B) is output.
// [R4] Arbitration-master clear: slave role, hold-acknowledge pin is an input.
// [R5] Arbitration-master set: master role, hold-acknowledge pin is driven.
// [R6] DMA support reset zero holds the state machine in initial state.
// [R7] Bus controller reset zero holds the external bus controller in reset.
// [R8] Channel A pass-all forwards every channel A interrupt to the queue.
// [R9] Channel B pass-all forwards every channel B interrupt to the queue.
// [R10] Software sets pin and role controls before releasing both reset controls.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module lbcc_top (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic local_bus_select_i,
  input wire logic [1:0] gp_pin_direction_i,
  input wire logic bus_ctrl_phase1_clk_i,
  input wire logic pci_phase1_clk_i,
  input wire lbcc_pkg::lbcc_ack_pair_t ack_int_chan_a_i,
  input wire lbcc_pkg::lbcc_ack_pair_t ack_int_chan_b_i,
  output logic ack_tx_chan_a_o,
  output logic ack_rx_chan_a_o,
  output logic ack_tx_chan_b_o,
  output logic ack_rx_chan_b_o,
  input wire logic hold_ack_int_i,
  input wire logic hold_acknowledge_i,
  output logic hold_acknowledge_o,
  output logic hold_acknowledge_oe_o,
  output logic hold_ack_seen_o,
  output logic arb_master_o,
  output logic dma_support_reset_n_o,
  output logic bus_ctrl_reset_n_o,
  input wire lbcc_pkg::lbcc_chan_irq_t chan_a_irq_i,
  input wire lbcc_pkg::lbcc_chan_irq_t chan_b_irq_i,
  output logic queue_irq_a_o,
  output logic queue_irq_b_o
);

  logic [lbcc_pkg::CTRL_W-1:0] ctrl_q;
  logic [lbcc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [lbcc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [lbcc_pkg::IRQ_W-1:0] irq_event;
  logic [31:0] rd_d;
  logic ack_q;
  logic access;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_mask;
  logic combine;
  logic combine_ack_pins;
  logic arb_master_select;
  logic dma_support_reset_n;
  logic bus_ctrl_reset_n;
  logic pass_all_irq_chan_a;
  logic pass_all_irq_chan_b;
  logic dma_rel_q;
  logic bus_rel_q;
  logic queue_a_q;
  logic queue_b_q;

  assign combine_ack_pins = ctrl_q[lbcc_pkg::CTRL_COMBINE_BIT];
  assign arb_master_select = ctrl_q[lbcc_pkg::CTRL_ARB_BIT];
  assign dma_support_reset_n = ctrl_q[lbcc_pkg::CTRL_DMA_RST_BIT];
  assign bus_ctrl_reset_n = ctrl_q[lbcc_pkg::CTRL_BUS_RST_BIT];
  assign pass_all_irq_chan_a = ctrl_q[lbcc_pkg::CTRL_PASS_A_BIT];
  assign pass_all_irq_chan_b = ctrl_q[lbcc_pkg::CTRL_PASS_B_BIT];

  // Bus slave: one wait state, ack for one cycle, then drops.
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctrl = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == lbcc_pkg::OFF_CTRL);
  assign wr_irq = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == lbcc_pkg::OFF_IRQ);
  assign wr_mask = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == lbcc_pkg::OFF_MASK);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end
  assign wb_ack_o = ack_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      lbcc_pkg::OFF_CTRL: rd_d[lbcc_pkg::CTRL_W-1:0] = ctrl_q;
      lbcc_pkg::OFF_STAT: rd_d[4:0] = {hold_ack_seen_o, bus_ctrl_reset_n, dma_support_reset_n,
                                       combine, local_bus_select_i};
      lbcc_pkg::OFF_IRQ: rd_d[lbcc_pkg::IRQ_W-1:0] = irq_stat_q;
      lbcc_pkg::OFF_MASK: rd_d[lbcc_pkg::IRQ_W-1:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  // Both reset controls come up zero, so the blocks stay held until software releases them.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= lbcc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wb_dat_i[lbcc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask_q <= lbcc_pkg::IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= wb_dat_i[lbcc_pkg::IRQ_W-1:0];
    end
  end

  // Acknowledge pin routing.
  assign combine = combine_ack_pins && local_bus_select_i; // R1

  always_comb begin
    if (combine) begin
      ack_tx_chan_a_o = ack_int_chan_a_i.ack_tx || ack_int_chan_a_i.ack_rx; // R2
      ack_tx_chan_b_o = ack_int_chan_b_i.ack_tx || ack_int_chan_b_i.ack_rx; // R2
      ack_rx_chan_a_o = gp_pin_direction_i[0] ? bus_ctrl_phase1_clk_i : 1'b0; // R3
      ack_rx_chan_b_o = gp_pin_direction_i[1] ? pci_phase1_clk_i : 1'b0; // R3
    end else begin
      ack_tx_chan_a_o = ack_int_chan_a_i.ack_tx; // R1
      ack_rx_chan_a_o = ack_int_chan_a_i.ack_rx; // R1
      ack_tx_chan_b_o = ack_int_chan_b_i.ack_tx; // R1
      ack_rx_chan_b_o = ack_int_chan_b_i.ack_rx; // R1
    end
  end

  // Arbitration role.
  assign arb_master_o = arb_master_select;
  assign hold_acknowledge_oe_o = arb_master_select; // R5
  assign hold_acknowledge_o = arb_master_select ? hold_ack_int_i : 1'b0; // R5
  assign hold_ack_seen_o = arb_master_select ? 1'b0 : hold_acknowledge_i; // R4

  assign dma_support_reset_n_o = dma_support_reset_n; // R6
  assign bus_ctrl_reset_n_o = bus_ctrl_reset_n; // R7

  // Interrupt forwarding: normally only the other kinds are queued.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      queue_a_q <= 1'b0;
      queue_b_q <= 1'b0;
    end else begin
      queue_a_q <= dma_support_reset_n && (chan_a_irq_i.other_irq ||
                   (pass_all_irq_chan_a && (|chan_a_irq_i[3:1]))); // R8
      queue_b_q <= dma_support_reset_n && (chan_b_irq_i.other_irq ||
                   (pass_all_irq_chan_b && (|chan_b_irq_i[3:1]))); // R9
    end
  end
  assign queue_irq_a_o = queue_a_q;
  assign queue_irq_b_o = queue_b_q;

  // Events: releases of each reset control and forwarded queue interrupts.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_rel_q <= 1'b0;
      bus_rel_q <= 1'b0;
    end else begin
      dma_rel_q <= dma_support_reset_n;
      bus_rel_q <= bus_ctrl_reset_n;
    end
  end
  assign irq_event = {queue_b_q, queue_a_q, bus_ctrl_reset_n && !bus_rel_q,
                      dma_support_reset_n && !dma_rel_q};

  // Set wins over a write-one clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < lbcc_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_irq && wb_dat_i[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Assertions.
  property p_sep_pins;
    @(posedge clock_i) disable iff (!reset_n_i)
      !combine |-> (ack_rx_chan_a_o == ack_int_chan_a_i.ack_rx);
  endproperty
  a_sep_pins: assert property (p_sep_pins) else $error("Separate rx ack wrong."); // R1

  property p_comb_pins;
    @(posedge clock_i) disable iff (!reset_n_i)
      (combine_ack_pins && local_bus_select_i) |->
        (ack_tx_chan_b_o == (ack_int_chan_b_i.ack_tx | ack_int_chan_b_i.ack_rx));
  endproperty
  a_comb_pins: assert property (p_comb_pins) else $error("Combined ack wrong."); // R2

  property p_clk_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
      (combine && !gp_pin_direction_i[0]) |-> !ack_rx_chan_a_o;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("Clock pin driven as input."); // R3

  property p_slave;
    @(posedge clock_i) disable iff (!reset_n_i)
      !arb_master_select |->
        !hold_acknowledge_oe_o && (hold_ack_seen_o == hold_acknowledge_i);
  endproperty
  a_slave: assert property (p_slave) else $error("Slave drives hold ack."); // R4

  property p_master;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_ctrl && wb_dat_i[lbcc_pkg::CTRL_ARB_BIT]) |=> hold_acknowledge_oe_o;
  endproperty
  a_master: assert property (p_master) else $error("Master not driving."); // R5

  property p_dma_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      !dma_support_reset_n_o |=> !queue_irq_a_o && !queue_irq_b_o;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("Held machine queued."); // R6

  property p_bus_rel;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_ctrl && wb_dat_i[lbcc_pkg::CTRL_BUS_RST_BIT]) |=> bus_ctrl_reset_n_o;
  endproperty
  a_bus_rel: assert property (p_bus_rel) else $error("Bus controller not released."); // R7

  property p_pass_a;
    @(posedge clock_i) disable iff (!reset_n_i)
      (dma_support_reset_n && pass_all_irq_chan_a && chan_a_irq_i.receive_pool_full_irq)
        |=> queue_irq_a_o;
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("Channel A not forwarded."); // R8

  property p_pass_b;
    @(posedge clock_i) disable iff (!reset_n_i)
      (dma_support_reset_n && !pass_all_irq_chan_b && !chan_b_irq_i.other_irq)
        |=> !queue_irq_b_o;
  endproperty
  a_pass_b: assert property (p_pass_b) else $error("Channel B leaked."); // R9

  property p_sep_other;
    @(posedge clock_i) disable iff (!reset_n_i)
      !combine |-> (ack_tx_chan_a_o == ack_int_chan_a_i.ack_tx) &&
        (ack_tx_chan_b_o == ack_int_chan_b_i.ack_tx) &&
        (ack_rx_chan_b_o == ack_int_chan_b_i.ack_rx);
  endproperty
  a_sep_other: assert property (p_sep_other) else $error("Separate ack pins wrong."); // R1

  property p_comb_a;
    @(posedge clock_i) disable iff (!reset_n_i)
      combine |->
        (ack_tx_chan_a_o == (ack_int_chan_a_i.ack_tx | ack_int_chan_a_i.ack_rx));
  endproperty
  a_comb_a: assert property (p_comb_a) else $error("Combined channel A ack wrong."); // R2

  property p_bus_clk_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
      (combine && gp_pin_direction_i[0]) |->
        (ack_rx_chan_a_o == bus_ctrl_phase1_clk_i);
  endproperty
  a_bus_clk_pin: assert property (p_bus_clk_pin) else $error("Bus clock not on freed pin."); // R3

  property p_pci_clk_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
      combine |->
        (ack_rx_chan_b_o == (gp_pin_direction_i[1] && pci_phase1_clk_i));
  endproperty
  a_pci_clk_pin: assert property (p_pci_clk_pin) else $error("Second clock pin wrong."); // R3

  property p_master_drive;
    @(posedge clock_i) disable iff (!reset_n_i)
      arb_master_select |->
        hold_acknowledge_oe_o && (hold_acknowledge_o == hold_ack_int_i) && !hold_ack_seen_o;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("Master hold ack wrong."); // R5

  property p_dma_rel;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_ctrl && wb_dat_i[lbcc_pkg::CTRL_DMA_RST_BIT]) |=> dma_support_reset_n_o;
  endproperty
  a_dma_rel: assert property (p_dma_rel) else $error("DMA support not released."); // R6

  property p_bus_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_ctrl && !wb_dat_i[lbcc_pkg::CTRL_BUS_RST_BIT]) |=> !bus_ctrl_reset_n_o;
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("Bus controller not held."); // R7

  property p_norm_a;
    @(posedge clock_i) disable iff (!reset_n_i)
      (dma_support_reset_n && !pass_all_irq_chan_a && !chan_a_irq_i.other_irq)
        |=> !queue_irq_a_o;
  endproperty
  a_norm_a: assert property (p_norm_a) else $error("Channel A leaked."); // R8

  property p_pass_b_fwd;
    @(posedge clock_i) disable iff (!reset_n_i)
      (dma_support_reset_n && pass_all_irq_chan_b && chan_b_irq_i.transmit_pool_ready_irq)
        |=> queue_irq_b_o;
  endproperty
  a_pass_b_fwd: assert property (p_pass_b_fwd) else $error("Channel B not forwarded."); // R9

  property p_ack_pulse;
    @(posedge clock_i) disable iff (!reset_n_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than one cycle.");

  property p_irq_set;
    @(posedge clock_i) disable iff (!reset_n_i)
      (|irq_event) |=> ((irq_stat_q & $past(irq_event)) == $past(irq_event));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Event lost against a clear.");

  // Cover points for the main scenarios.
  c_combine: cover property (@(posedge clock_i) disable iff (!reset_n_i) combine);
  c_master: cover property (@(posedge clock_i) disable iff (!reset_n_i) hold_acknowledge_oe_o);
  c_irq: cover property (@(posedge clock_i) disable iff (!reset_n_i) irq_o);
  c_pass_a: cover property (@(posedge clock_i) disable iff (!reset_n_i) queue_irq_a_o);
  c_slave_seen: cover property (@(posedge clock_i) disable iff (!reset_n_i) hold_ack_seen_o);

endmodule : lbcc_top

// *** core/lbcc_pkg.sv ***
// Package for the local bus configuration controls block.
package lbcc_pkg;

  localparam int unsigned ADDR_W = 4;

  // Register byte offsets.
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_IRQ = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hC;

  // Control register bit positions.
  localparam int unsigned CTRL_COMBINE_BIT = 0;
  localparam int unsigned CTRL_ARB_BIT = 1;
  localparam int unsigned CTRL_DMA_RST_BIT = 2;
  localparam int unsigned CTRL_BUS_RST_BIT = 3;
  localparam int unsigned CTRL_PASS_A_BIT = 4;
  localparam int unsigned CTRL_PASS_B_BIT = 5;
  localparam int unsigned CTRL_W = 6;

  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam int unsigned IRQ_W = 4;

  // Interrupt status bits.
  localparam int unsigned IRQ_DMA_REL_BIT = 0;
  localparam int unsigned IRQ_BUS_REL_BIT = 1;
  localparam int unsigned IRQ_QUEUE_A_BIT = 2;
  localparam int unsigned IRQ_QUEUE_B_BIT = 3;

  // Interrupt kinds a channel raises towards the DMA support state machine.
  typedef struct packed {
    logic receive_pool_full_irq;
    logic transmit_pool_ready_irq;
    logic receive_message_complete_irq;
    logic other_irq;
  } lbcc_chan_irq_t;

  // Per-channel DMA acknowledge pins.
  typedef struct packed {
    logic ack_tx;
    logic ack_rx;
  } lbcc_ack_pair_t;

endpackage : lbcc_pkg

// *** verif/lbcc_far_end.sv ***
// Far-end arbiter model that owns the hold-acknowledge pin while the block is a slave.
`timescale 1ns/10ps
module lbcc_far_end (
  input wire logic clock_i,
  input wire logic hold_oe_i,
  input wire logic level_i,
  output logic pin_o
);
  logic last_q = 1'b0;
  always_ff @(posedge clock_i) begin
    last_q <= pin_o;
  end
  // Once released, the pin shows a changing value so nothing reads a stale level.
  always_comb begin
    pin_o = hold_oe_i ? ~last_q : level_i;
  end
endmodule : lbcc_far_end

// *** verif/testbench.sv ***
// Self-checking bench for the local bus configuration controls.
`timescale 1ns/10ps
module testbench;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc = 1'b0, we = 1'b0, lbsel = 1'b0, hint = 1'b0, hlvl = 1'b0;
  logic [3:0] adr = 4'h0, ia = 4'h0, ib = 4'h0, pins;
  logic ck_bus = 1'b1, ck_pci = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [1:0] dir = 2'h0, aka = 2'h0, akb = 2'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic ack, irq, hoe, hout, seen, arb, drst, brst, qa, qb, far, hpin, txa, rxa, txb, rxb;
  int miscompares = 0;
  int num_checks = 0;
  localparam logic [11:0] ROWS [5] = '{12'h799, 12'hB66, 12'hF6E, 12'hC00, 12'hD8C};
  always #5 clock_i = ~clock_i;
  assign pins = {txa, rxa, txb, rxb};
  assign hpin = hoe ? hout : far;
  lbcc_top i_lbcc_top (.clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .local_bus_select_i(lbsel),
    .gp_pin_direction_i(dir), .bus_ctrl_phase1_clk_i(ck_bus), .pci_phase1_clk_i(ck_pci),
    .ack_int_chan_a_i(aka), .ack_int_chan_b_i(akb), .ack_tx_chan_a_o(txa),
    .ack_rx_chan_a_o(rxa), .ack_tx_chan_b_o(txb), .ack_rx_chan_b_o(rxb),
    .hold_ack_int_i(hint), .hold_acknowledge_i(hpin), .hold_acknowledge_o(hout),
    .hold_acknowledge_oe_o(hoe), .hold_ack_seen_o(seen), .arb_master_o(arb),
    .dma_support_reset_n_o(drst), .bus_ctrl_reset_n_o(brst), .chan_a_irq_i(ia),
    .chan_b_irq_i(ib), .queue_irq_a_o(qa), .queue_irq_b_o(qb));
  lbcc_far_end i_lbcc_far_end (.clock_i(clock_i), .hold_oe_i(hoe), .level_i(hlvl),
    .pin_o(far));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5000) @(posedge clock_i);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk({drst, brst, hoe, irq}, 32'h0);
    wb(1'b0, lbcc_pkg::OFF_CTRL, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rdat, 32'h0);
    $display("reset test done");
    for (int r = 0; r < 5; r++) begin
      wb(1'b1, lbcc_pkg::OFF_CTRL, {31'h0, ROWS[r][11]});
      @(posedge clock_i);
      lbsel <= ROWS[r][10];
      dir <= ROWS[r][9:8];
      aka <= ROWS[r][7:6];
      akb <= ROWS[r][5:4];
      @(posedge clock_i);
      #1;
      chk(pins, ROWS[r][3:0]);
    end
    $display("pin table done");
    @(posedge clock_i);
    ck_bus <= 1'b0;
    ck_pci <= 1'b1;
    dir <= 2'h3;
    @(posedge clock_i);
    chk({rxa, rxb}, 32'h1);
    wb(1'b0, lbcc_pkg::OFF_STAT, 32'h0);
    chk(rdat, 32'h3);
    $display("clock pin test done");
    hint <= 1'b1;
    hlvl <= 1'b1;
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0000_0002);
    chk({hoe, hout, seen, arb}, 32'hD);
    hint <= 1'b0;
    @(posedge clock_i);
    chk(hout, 32'h0);
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0);
    chk({hoe, seen, arb}, 32'h2);
    hlvl <= 1'b0;
    @(posedge clock_i);
    chk(seen, 32'h0);
    sel <= 4'hE;
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0000_000C);
    chk({drst, brst}, 32'h0);
    sel <= 4'hF;
    $display("arbitration test done");
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0000_000C);
    chk({drst, brst, irq}, 32'h6);
    wb(1'b1, lbcc_pkg::OFF_MASK, 32'h0000_0003);
    chk(irq, 32'h1);
    wb(1'b0, lbcc_pkg::OFF_IRQ, 32'h0);
    chk(rdat, 32'h3);
    wb(1'b1, lbcc_pkg::OFF_IRQ, 32'h0000_0003);
    chk(irq, 32'h0);
    $display("interrupt test done");
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        wb(1'b1, lbcc_pkg::OFF_CTRL, (p == 1) ? 32'h0000_003C : 32'h0000_000C);
        ia <= 4'h8 >> k;
        ib <= 4'h8 >> k;
        @(posedge clock_i);
        @(posedge clock_i);
        #1;
        chk({qa, qb}, (p == 1 || k == 3) ? 32'h3 : 32'h0);
      end
    end
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0000_0030);
    repeat (2) @(posedge clock_i);
    #1;
    chk({qa, qb}, 32'h0);
    $display("queue test done");
    wb(1'b1, lbcc_pkg::OFF_CTRL, 32'h0000_003E);
    wb(1'b1, lbcc_pkg::OFF_MASK, 32'h0000_000F);
    wb(1'b0, lbcc_pkg::OFF_IRQ, 32'h0);
    chk(rdat, 32'hF);
    chk({arb, irq}, 32'h3);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk({drst, brst, hoe, arb, irq, qa, qb}, 32'h0);
    wb(1'b0, lbcc_pkg::OFF_CTRL, 32'h0);
    chk(rdat, 32'h0);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : testbench
